// [verilog/pbd_pkg.sv]
package pbd_pkg;

  // Prefix byte values.
  localparam logic [7:0] PBD_Y_SUBSTITUTE_PREFIX = 8'h90;
  localparam logic [7:0] PBD_Y_INDIRECT_PREFIX   = 8'h91;
  localparam logic [7:0] PBD_INDIRECT_PREFIX     = 8'h92;

  // Instruction length limits in bytes.
  localparam logic [2:0] PBD_LEN_MIN = 3'h1;
  localparam logic [2:0] PBD_LEN_MAX = 3'h4;

  typedef enum logic [1:0] {
    PBD_PFX_NONE = 2'h0,
    PBD_PFX_Y    = 2'h1,
    PBD_PFX_IND  = 2'h2,
    PBD_PFX_YIND = 2'h3
  } pbd_pfx_t;

  typedef enum logic [3:0] {
    PBD_M_INH      = 4'h0,
    PBD_M_IMM      = 4'h1,
    PBD_M_DIR_S    = 4'h2,
    PBD_M_DIR_L    = 4'h3,
    PBD_M_DBIT     = 4'h4,
    PBD_M_DREL     = 4'h5,
    PBD_M_REL      = 4'h6,
    PBD_M_IX       = 4'h7,
    PBD_M_IX_S     = 4'h8,
    PBD_M_IX_L     = 4'h9,
    PBD_M_IND_S    = 4'ha,
    PBD_M_IND_L    = 4'hb,
    PBD_M_IND_BIT  = 4'hc,
    PBD_M_IND_REL  = 4'hd,
    PBD_M_IND_IX_S = 4'he,
    PBD_M_IND_IX_L = 4'hf
  } pbd_mode_t;

  // Base class of an opcode before any prefix is applied.
  typedef struct packed {
    pbd_mode_t  mode;
    logic [1:0] ext_cnt;
  } pbd_cls_t;

  // Decoded instruction handed to the execution datapath.
  typedef struct packed {
    pbd_pfx_t   pfx;
    logic [7:0] opcode;
    pbd_mode_t  mode;
    logic       use_y;
    logic       illegal;
    logic [2:0] len;
    logic [15:0] ext;
  } pbd_dec_t;

endpackage

// [verilog/pbd_opclass.sv]
`timescale 1ns/1ns
module pbd_opclass
  import pbd_pkg::*;
(
  // Opcode in.
  input  wire logic [7:0] opcode_i,
  // Base class out.
  output pbd_cls_t        cls_o
);

  // The high nibble selects the addressing class of all 256 opcodes.
  always_comb begin
    case (opcode_i[7:4])
      4'h0:    cls_o = '{PBD_M_DREL,  2'h2};
      4'h1:    cls_o = '{PBD_M_DBIT,  2'h1};
      4'h2:    cls_o = '{PBD_M_REL,   2'h1};
      4'h3:    cls_o = '{PBD_M_DIR_S, 2'h1};
      4'h6:    cls_o = '{PBD_M_IX_S,  2'h1};
      4'h7:    cls_o = '{PBD_M_IX,    2'h0};
      4'ha:    cls_o = '{PBD_M_IMM,   2'h1};
      4'hb:    cls_o = '{PBD_M_DIR_S, 2'h1};
      4'hc:    cls_o = '{PBD_M_DIR_L, 2'h2};
      4'hd:    cls_o = '{PBD_M_IX_L,  2'h2};
      4'he:    cls_o = '{PBD_M_IX_S,  2'h1};
      4'hf:    cls_o = '{PBD_M_IX,    2'h0};
      default: cls_o = '{PBD_M_INH,   2'h0};
    endcase
  end

endmodule // pbd_opclass

// [verilog/pbd_decoder.sv]
// How it works
// [RULE1] Every one of the 256 opcodes, covering all 63 instructions, decodes.
// [RULE2] An instruction is one to four bytes, prefix and extension included.
// [RULE3] Three prefix values exist; each changes how the next opcode reads.
// [RULE4] Prefix comes right before opcode; zero to two address bytes follow.
// [RULE5] A prefix only acts on the opcode forms it can convert.
// [RULE6] Prefix 90 turns X immediate, direct, indexed or inherent forms into Y.
// [RULE7] Prefix 92 turns direct, direct bit, direct relative into indirect forms.
// [RULE8] Prefix 92 turns X indexed into indirect X indexed.
// [RULE9] Prefix 91 turns X indirect indexed into Y indirect indexed.
// [RULE10] Non-prefix first bytes are plain opcodes; one prefix per instruction.
`timescale 1ns/1ns
module pbd_decoder
  import pbd_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // Instruction bytes from program memory.
  input  wire logic       byte_valid_i,
  input  wire logic [7:0] byte_i,
  output logic            byte_ready_o,
  // Decoded instruction to the datapath.
  output logic            dec_valid_o,
  input  wire logic       dec_ready_i,
  output pbd_dec_t        dec_o
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPC  = 2'b01,
    ST_EXT  = 2'b11,
    ST_OUT  = 2'b10
  } pbd_state_t;

  pbd_state_t state;
  pbd_state_t next_state;
  pbd_pfx_t   pfx;
  pbd_pfx_t   cur_pfx;
  pbd_cls_t   cls;
  pbd_mode_t  base_mode;
  pbd_mode_t  next_mode;
  logic       next_use_y;
  logic       next_illegal;
  logic [1:0] ext_left;
  logic [2:0] bytes_seen;
  logic       take;
  logic       byte_is_pfx;
  logic       opc_take;
  pbd_pfx_t   byte_pfx;

  assign byte_ready_o = (state != ST_OUT);
  assign dec_valid_o  = (state == ST_OUT);
  assign take         = byte_valid_i && byte_ready_o;

  always_comb begin
    case (byte_i)
      PBD_Y_SUBSTITUTE_PREFIX: byte_pfx = PBD_PFX_Y;
      PBD_INDIRECT_PREFIX:     byte_pfx = PBD_PFX_IND;
      PBD_Y_INDIRECT_PREFIX:   byte_pfx = PBD_PFX_YIND;
      default:                 byte_pfx = PBD_PFX_NONE;
    endcase
  end

  // [RULE3] three prefix values
  assign byte_is_pfx = (byte_pfx != PBD_PFX_NONE);
  // [RULE10] plain first byte
  assign opc_take = take && ((state == ST_OPC) || (state == ST_IDLE && !byte_is_pfx));
  assign cur_pfx  = (state == ST_OPC) ? pfx : PBD_PFX_NONE;

  // [RULE1] all opcodes classified
  pbd_opclass pbd_opclass_i (
    .opcode_i (byte_i),
    .cls_o    (cls)
  );

  // Applies the held prefix to the opcode's base class.
  always_comb begin
    next_mode    = cls.mode;
    next_use_y   = 1'b0;
    next_illegal = 1'b0;
    case (cur_pfx)
      // [RULE6] Y substitution
      PBD_PFX_Y: begin
        case (cls.mode)
          PBD_M_INH, PBD_M_IMM, PBD_M_DIR_S, PBD_M_DIR_L,
          PBD_M_IX, PBD_M_IX_S, PBD_M_IX_L: next_use_y = 1'b1;
          default: next_illegal = 1'b1;
        endcase
      end
      // [RULE7] direct to indirect, [RULE8] X indexed to indirect
      PBD_PFX_IND: begin
        case (cls.mode)
          PBD_M_DIR_S: next_mode = PBD_M_IND_S;
          PBD_M_DIR_L: next_mode = PBD_M_IND_L;
          PBD_M_DBIT:  next_mode = PBD_M_IND_BIT;
          PBD_M_DREL:  next_mode = PBD_M_IND_REL;
          PBD_M_IX_S:  next_mode = PBD_M_IND_IX_S;
          PBD_M_IX_L:  next_mode = PBD_M_IND_IX_L;
          default:     next_illegal = 1'b1;
        endcase
      end
      // [RULE9] Y indirect indexed
      PBD_PFX_YIND: begin
        case (cls.mode)
          PBD_M_IX_S: begin
            next_mode  = PBD_M_IND_IX_S;
            next_use_y = 1'b1;
          end
          PBD_M_IX_L: begin
            next_mode  = PBD_M_IND_IX_L;
            next_use_y = 1'b1;
          end
          default: next_illegal = 1'b1;
        endcase
      end
      default: next_illegal = 1'b0;
    endcase
    // [RULE10] second prefix flagged
    if (state == ST_OPC && byte_is_pfx) begin
      next_illegal = 1'b1;
    end
    // [RULE5] ignore unusable prefix
    if (next_illegal) begin
      next_mode  = cls.mode;
      next_use_y = 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          if (byte_is_pfx) begin
            next_state = ST_OPC;
          end else begin
            next_state = (cls.ext_cnt == 2'h0) ? ST_OUT : ST_EXT;
          end
        end
      end
      ST_OPC: begin
        if (take) begin
          next_state = (cls.ext_cnt == 2'h0) ? ST_OUT : ST_EXT;
        end
      end
      // [RULE4] gather address bytes
      ST_EXT: begin
        if (take && ext_left == 2'h1) begin
          next_state = ST_OUT;
        end
      end
      ST_OUT: begin
        if (dec_ready_i) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pfx <= PBD_PFX_NONE;
    end else if (take && state == ST_IDLE) begin
      pfx <= byte_pfx;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_left <= 2'h0;
    end else if (opc_take) begin
      ext_left <= cls.ext_cnt;
    end else if (take && state == ST_EXT) begin
      ext_left <= ext_left - 2'h1;
    end
  end

  // [RULE2] length counted
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bytes_seen <= 3'h0;
    end else if (take && state == ST_IDLE) begin
      bytes_seen <= 3'h1;
    end else if (take) begin
      bytes_seen <= bytes_seen + 3'h1;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dec_o     <= '0;
      base_mode <= PBD_M_INH;
    end else if (opc_take) begin
      dec_o.pfx     <= cur_pfx;
      dec_o.opcode  <= byte_i;
      dec_o.mode    <= next_mode;
      dec_o.use_y   <= next_use_y;
      dec_o.illegal <= next_illegal;
      dec_o.len     <= {2'h0, cur_pfx != PBD_PFX_NONE} + PBD_LEN_MIN + {1'b0, cls.ext_cnt};
      dec_o.ext     <= '0;
      base_mode     <= cls.mode;
    end else if (take && state == ST_EXT) begin
      dec_o.ext <= {dec_o.ext[7:0], byte_i};
    end
  end

  hold_output_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE1]
    dec_valid_o && !dec_ready_i |=> dec_valid_o && $stable(dec_o))
    else $error("Decoded output changed while stalled.");
  len_range_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE2]
    dec_valid_o |-> dec_o.len >= PBD_LEN_MIN && dec_o.len <= PBD_LEN_MAX)
    else $error("Instruction length out of range.");
  pfx_capture_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE3]
    take && state == ST_IDLE && byte_i == PBD_INDIRECT_PREFIX |=> state == ST_OPC && pfx == PBD_PFX_IND)
    else $error("Indirect prefix not held.");
  byte_count_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE4]
    dec_valid_o |-> dec_o.len == bytes_seen)
    else $error("Fetched byte count disagrees with length.");
  pfx_ignored_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE5]
    dec_valid_o && dec_o.illegal |-> !dec_o.use_y && dec_o.mode == base_mode)
    else $error("Unusable prefix altered the opcode.");
  y_subst_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE6]
    dec_valid_o && dec_o.pfx == PBD_PFX_Y && !dec_o.illegal |-> dec_o.use_y && dec_o.mode == base_mode)
    else $error("Y substitution wrong.");
  ind_direct_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE7]
    dec_valid_o && dec_o.pfx == PBD_PFX_IND && base_mode == PBD_M_DBIT |-> dec_o.mode == PBD_M_IND_BIT)
    else $error("Direct bit not made indirect.");
  ind_index_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE8]
    dec_valid_o && dec_o.pfx == PBD_PFX_IND && base_mode == PBD_M_IX_S |-> dec_o.mode == PBD_M_IND_IX_S && !dec_o.use_y)
    else $error("X indexed not made indirect.");
  y_indirect_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE9]
    dec_valid_o && dec_o.pfx == PBD_PFX_YIND && !dec_o.illegal |-> dec_o.use_y && dec_o.mode inside {PBD_M_IND_IX_S, PBD_M_IND_IX_L})
    else $error("Y indirect indexed wrong.");
  one_prefix_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE10]
    take && state == ST_OPC && byte_is_pfx |=> dec_o.illegal && state != ST_OPC)
    else $error("Second prefix not flagged.");

  y_seen_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    dec_valid_o && dec_o.use_y && dec_o.len == 3'h3);
  ind_seen_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    dec_valid_o && dec_o.mode == PBD_M_IND_REL && dec_o.len == PBD_LEN_MAX);
  plain_seen_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    dec_valid_o && dec_o.pfx == PBD_PFX_NONE && dec_o.len == PBD_LEN_MIN);

endmodule // pbd_decoder

// [bench/pbd_prog_mem.sv]
`timescale 1ns/1ns
module pbd_prog_mem (
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // Byte stream to the decoder.
  input  wire logic       byte_ready_i,
  output logic            byte_valid_o = 1'b0,
  output logic [7:0]      byte_o = 8'h00
);
  logic [7:0] q[$];
  int         slow = 0;
  int         hold = 0;

  // Queues bytes first byte in the top lane; dly idle cycles follow each byte.
  task automatic put(input logic [31:0] w, input int cnt, input int dly);
    for (int k = cnt - 1; k >= 0; k--) q.push_back(w[8*k +: 8]);
    slow = dly;
  endtask

  // Idle cycles show a changing value so a stale byte is never reused.
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      byte_valid_o <= 1'b0;
      hold         <= 0;
    end else if (!byte_valid_o || byte_ready_i) begin
      if (byte_valid_o) void'(q.pop_front());
      if (byte_valid_o) hold <= 0;
      else hold <= hold + 1;
      if (q.size() != 0 && (byte_valid_o ? slow == 0 : hold + 1 >= slow)) begin
        byte_valid_o <= 1'b1;
        byte_o       <= q[0];
      end else begin
        byte_valid_o <= 1'b0;
        byte_o       <= ~byte_o;
      end
    end
  end
endmodule // pbd_prog_mem

// [bench/pbd_decoder_bench.sv]
`timescale 1ns/1ns
module pbd_decoder_bench;
  import pbd_pkg::*;
  logic       mclk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       byte_valid_i;
  logic [7:0] byte_i;
  logic       byte_ready_o;
  logic       dec_valid_o;
  logic       dec_ready_i = 1'b0;
  pbd_dec_t   dec_o;
  int         error_cnt = 0;
  int         samples_checked = 0;

  always #2 mclk_i = ~mclk_i;

  pbd_decoder pbd_decoder_i (
    .mclk_i      (mclk_i),
    .sys_rst_i   (sys_rst_i),
    .byte_valid_i(byte_valid_i),
    .byte_i      (byte_i),
    .byte_ready_o(byte_ready_o),
    .dec_valid_o (dec_valid_o),
    .dec_ready_i (dec_ready_i),
    .dec_o       (dec_o)
  );

  pbd_prog_mem pbd_prog_mem_i (
    .mclk_i      (mclk_i),
    .sys_rst_i   (sys_rst_i),
    .byte_ready_i(byte_ready_o),
    .byte_valid_o(byte_valid_i),
    .byte_o      (byte_i)
  );

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("mismatches=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One instruction: feed bytes, judge the result, hold it slow cycles, accept.
  task automatic xfer(input logic [31:0] w, input int cnt, input pbd_pfx_t p,
                      input pbd_mode_t m, input logic y, input logic bad, input int slow);
    int e;
    int k;
    e = cnt - 1 - int'(p != PBD_PFX_NONE);
    @(negedge mclk_i);
    pbd_prog_mem_i.put(w, cnt, slow);
    for (k = 0; k < 60 && dec_valid_o !== 1'b1; k++) @(negedge mclk_i);
    if (k == 60) begin
      error_cnt++;
      finish_test();
    end
    check(dec_o.pfx, p);
    check(dec_o.opcode, w[8*e +: 8]);
    check(dec_o.mode, m);
    if (bad === 1'b0) check(dec_o.use_y, y);
    check(dec_o.illegal, bad);
    check(dec_o.len, cnt);
    check(dec_o.ext, w[15:0] & ((e == 2) ? 16'hffff : (e == 1) ? 16'h00ff : 16'h0000));
    check(pbd_prog_mem_i.q.size(), 0);
    check(byte_ready_o, 1'b0);
    repeat (slow) begin
      @(negedge mclk_i);
      check(dec_valid_o, 1'b1);
    end
    @(posedge mclk_i) dec_ready_i <= 1'b1;
    @(posedge mclk_i) dec_ready_i <= 1'b0;
    @(negedge mclk_i) check(dec_valid_o, 1'b0);
  endtask

  task automatic t_reset;
    repeat (5) @(negedge mclk_i);
    check(byte_ready_o, 1'b1);
    check(dec_valid_o, 1'b0);
    check(dec_o, 40'h0);
    @(posedge mclk_i) sys_rst_i <= 1'b0;
  endtask

  task automatic t_plain;
    xfer(32'h9d, 1, PBD_PFX_NONE, PBD_M_INH, 1'b0, 1'b0, 0);
    xfer(32'ha612, 2, PBD_PFX_NONE, PBD_M_IMM, 1'b0, 1'b0, 1);
    xfer(32'hb712, 2, PBD_PFX_NONE, PBD_M_DIR_S, 1'b0, 1'b0, 0);
    xfer(32'hc61234, 3, PBD_PFX_NONE, PBD_M_DIR_L, 1'b0, 1'b0, 0);
    xfer(32'h7f, 1, PBD_PFX_NONE, PBD_M_IX, 1'b0, 1'b0, 0);
    xfer(32'he605, 2, PBD_PFX_NONE, PBD_M_IX_S, 1'b0, 1'b0, 0);
    xfer(32'hd61234, 3, PBD_PFX_NONE, PBD_M_IX_L, 1'b0, 1'b0, 2);
    xfer(32'h2005, 2, PBD_PFX_NONE, PBD_M_REL, 1'b0, 1'b0, 0);
    xfer(32'h1012, 2, PBD_PFX_NONE, PBD_M_DBIT, 1'b0, 1'b0, 0);
    xfer(32'h001205, 3, PBD_PFX_NONE, PBD_M_DREL, 1'b0, 1'b0, 0);
  endtask

  task automatic t_y;
    xfer(32'h907f, 2, PBD_PFX_Y, PBD_M_IX, 1'b1, 1'b0, 0);
    xfer(32'h90a612, 3, PBD_PFX_Y, PBD_M_IMM, 1'b1, 1'b0, 1);
    xfer(32'h909d, 2, PBD_PFX_Y, PBD_M_INH, 1'b1, 1'b0, 0);
    xfer(32'h90b712, 3, PBD_PFX_Y, PBD_M_DIR_S, 1'b1, 1'b0, 2);
    xfer(32'h90d61234, 4, PBD_PFX_Y, PBD_M_IX_L, 1'b1, 1'b0, 0);
  endtask

  task automatic t_ind;
    xfer(32'h92b712, 3, PBD_PFX_IND, PBD_M_IND_S, 1'b0, 1'b0, 0);
    xfer(32'h92c41234, 4, PBD_PFX_IND, PBD_M_IND_L, 1'b0, 1'b0, 2);
    xfer(32'h921012, 3, PBD_PFX_IND, PBD_M_IND_BIT, 1'b0, 1'b0, 0);
    xfer(32'h92001205, 4, PBD_PFX_IND, PBD_M_IND_REL, 1'b0, 1'b0, 0);
    xfer(32'h92e605, 3, PBD_PFX_IND, PBD_M_IND_IX_S, 1'b0, 1'b0, 0);
    xfer(32'h92d61234, 4, PBD_PFX_IND, PBD_M_IND_IX_L, 1'b0, 1'b0, 1);
  endtask

  task automatic t_yind;
    xfer(32'h91e605, 3, PBD_PFX_YIND, PBD_M_IND_IX_S, 1'b1, 1'b0, 0);
    xfer(32'h91d61234, 4, PBD_PFX_YIND, PBD_M_IND_IX_L, 1'b1, 1'b0, 0);
  endtask

  task automatic t_bad;
    xfer(32'h919d, 2, PBD_PFX_YIND, PBD_M_INH, 1'b0, 1'b1, 0);
    xfer(32'h92a612, 3, PBD_PFX_IND, PBD_M_IMM, 1'b0, 1'b1, 0);
    xfer(32'h9090, 2, PBD_PFX_Y, PBD_M_INH, 1'b0, 1'b1, 0);
  endtask

  // A reset in mid-instruction drops the held prefix and the old result.
  task automatic t_midrst;
    @(negedge mclk_i);
    pbd_prog_mem_i.put(32'h92, 1, 0);
    repeat (3) @(negedge mclk_i);
    check(pbd_prog_mem_i.q.size(), 0);
    check(dec_valid_o, 1'b0);
    @(posedge mclk_i) sys_rst_i <= 1'b1;
    repeat (2) @(negedge mclk_i);
    check(byte_ready_o, 1'b1);
    check(dec_valid_o, 1'b0);
    check(dec_o, 40'h0);
    @(posedge mclk_i) sys_rst_i <= 1'b0;
    xfer(32'h9d, 1, PBD_PFX_NONE, PBD_M_INH, 1'b0, 1'b0, 0);
  endtask

  initial begin
    t_reset();
    t_plain();
    t_y();
    t_ind();
    t_yind();
    t_bad();
    t_midrst();
    finish_test();
  end
endmodule // pbd_decoder_bench
